//--- common/psac_defines.svh
`ifndef PSAC_DEFINES_SVH
`define PSAC_DEFINES_SVH

// Fixed upper three bits of the seven-bit bus address.
`define PSAC_ADDR_PREFIX      3'h6
// Broadcast address, seven bits.
`define PSAC_BCAST_ADDR       7'h00
// Fixed slot address used in the factory mode; the value is arbitrary.
`define PSAC_FACTORY_SLOT     4'h0
// Number of decoded unit and rack positions.
`define PSAC_UNIT_MAX         4'ha
`define PSAC_RACK_MAX         4'h8
// Setpoint code used while the default setpoint is selected.
`define PSAC_SETPOINT_DEFAULT 8'h80
// Firmware command code that takes over the setpoint.
`define PSAC_CMD_SETPOINT     8'h21
// Timing figures in microseconds and the clock rate in MHz.
`define PSAC_CLK_MHZ          50
`define PSAC_PG_WARN_US       2000
`define PSAC_RISE_MAX_US      50000
`define PSAC_START_DELAY_US   2000
`define PSAC_BLINK_HALF_US    250000
// Cycle counts derived from the figures above.
`define PSAC_PG_WARN_CYC      (`PSAC_PG_WARN_US * `PSAC_CLK_MHZ)
`define PSAC_RISE_MAX_CYC     (`PSAC_RISE_MAX_US * `PSAC_CLK_MHZ)
`define PSAC_START_DELAY_CYC  (`PSAC_START_DELAY_US * `PSAC_CLK_MHZ + 1)
`define PSAC_BLINK_HALF_CYC   (`PSAC_BLINK_HALF_US * `PSAC_CLK_MHZ)

`endif

//--- common/psac_pkg.sv
package psac_pkg;

    // Outcome of an address phase seen by the bus front end.
    typedef struct packed {
        logic       hit;
        logic       bcast;
        logic       invalid;
    } psac_match_t;

    // Output sequencing states.
    typedef enum logic [2:0] {
        PSAC_OFF,
        PSAC_DELAY,
        PSAC_RISE,
        PSAC_ON,
        PSAC_WARN
    } psac_seq_t;

    // Firmware command strobe with its code and data.
    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic [7:0] data;
    } psac_cmd_t;

endpackage

//--- rtl/psac_slot_decode.sv
`timescale 1ns/1ps
// Combinational map from decoded unit and rack numbers to the slot address.
module psac_slot_decode (
    // Decoded positions, 1-based, 0 meaning invalid.
    input  wire logic [3:0] unit_num,
    input  wire logic [3:0] rack_num,
    // Resolved slot address.
    output logic      [3:0] slot_addr
);

    // Table lookup by formula across the four unit groups.
    always_comb begin
        logic [5:0] u;
        logic [5:0] r;
        logic [5:0] a;
        u = {2'h0, unit_num};
        r = {2'h0, rack_num};
        a = 6'h00;
        if (r >= 6'h1 && r <= 6'h8) begin
            if (u >= 6'h1 && u <= 6'h4) begin
                if (r <= 6'h4) begin
                    a = 6'h4 * (r - 6'h1) + (u - 6'h1);
                end else if (r >= 6'h6) begin
                    a = 6'h5 * (r - 6'h6) + (u - 6'h1);
                end
            end else if (u == 6'h5) begin
                if (r >= 6'h6) begin
                    a = 6'h5 * (r - 6'h6) + 6'h4;
                end
            end else if (u == 6'h6 || u == 6'h7) begin
                a = 6'h2 * (r - 6'h1) + (u - 6'h6);
            end else if (u >= 6'h8 && u <= 6'ha) begin
                if (r >= 6'h4) begin
                    a = 6'h3 * (r - 6'h4) + (u - 6'h8);
                end
            end
        end
        slot_addr = a[3:0];
    end

endmodule // psac_slot_decode

//--- rtl/psac_level_decode.sv
`timescale 1ns/1ps
// Quantiser from an eight-bit level code (full scale 3.30) to a position number.
module psac_level_decode (
    // Select: 0 for the unit input, 1 for the rack input.
    input  wire logic       is_rack,
    // Digitised level, 8'hff standing for 3.30.
    input  wire logic [7:0] level,
    // Position 1..10 or 1..8; 0 for an invalid level.
    output logic      [3:0] pos
);

    // Thresholds sit midway between nominal levels, scaled by 255/3.30.
    always_comb begin
        pos = 4'h0;
        if (!is_rack) begin
            if      (level >= 8'hf2) pos = 4'h0; // 3.30 reads invalid
            else if (level >= 8'hdb) pos = 4'h1;
            else if (level >= 8'hc2) pos = 4'h2;
            else if (level >= 8'ha9) pos = 4'h3;
            else if (level >= 8'h90) pos = 4'h4;
            else if (level >= 8'h77) pos = 4'h5;
            else if (level >= 8'h5e) pos = 4'h6;
            else if (level >= 8'h45) pos = 4'h7;
            else if (level >= 8'h2c) pos = 4'h8;
            else if (level >= 8'h0e) pos = 4'h9;
            else                     pos = 4'ha;
        end else begin
            if      (level >= 8'hee) pos = 4'h1;
            else if (level >= 8'hc8) pos = 4'h2;
            else if (level >= 8'ha2) pos = 4'h3;
            else if (level >= 8'h80) pos = 4'h4;
            else if (level >= 8'h5d) pos = 4'h5;
            else if (level >= 8'h3a) pos = 4'h6;
            else if (level >= 8'h13) pos = 4'h7;
            else                     pos = 4'h8;
        end
    end

endmodule // psac_level_decode

//--- rtl/psac_owner.sv
`timescale 1ns/1ps
`include "psac_defines.svh"
// Function
// - Answer address 110 plus slot bits.
// - Address byte bit zero selects write/read.
// - Also accept all-zero broadcast writes.
// - Broadcast read flags invalid, not served.
// - Unit levels decode units 1-10, 3.30 invalid.
// - Rack levels decode racks 1-8.
// - Racks 1-4 units 1-4 formula; others zero.
// - Racks 6-8 units 1-5 formula.
// - Units 6-7 and 8-10 formulas.
// - Mode pin selects serial or RS485.
// - RS485 mode uses fixed internal address.
// - Setpoint follows pin until command 0x21.
// - Firmware ownership lasts until bias reset.
// - High or open pin selects default setpoint.
// - Output on only with remote high, no off command.
// - Power-good drops 2ms before output loss; here on hold_expiring or input loss, and with the output on an off request.
// - Power-good asserts after output in regulation.
// - Wait over 2ms after input returns; here only from PSAC_OFF, while PSAC_WARN goes straight back to PSAC_RISE.
// - Input-ok indicator blinks on low input.
module psac_owner (
    // Clock and bias-power reset.
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Strapped select levels and mode pin.
    input  wire logic [7:0]           unit_select_input,
    input  wire logic [7:0]           rack_select_input,
    input  wire logic                 mode_rs485,
    // Address phase from the bus front end.
    input  wire logic                 addr_valid,
    input  wire logic [7:0]           addr_byte,
    output psac_pkg::psac_match_t     addr_match,
    // Firmware command strobe.
    input  wire psac_pkg::psac_cmd_t  fw_cmd,
    input  wire logic                 fw_off_cmd,
    input  wire logic                 fw_on_cmd,
    // Setpoint pin level and its open detect.
    input  wire logic [7:0]           setpoint_pin,
    input  wire logic                 setpoint_pin_open,
    input  wire logic                 setpoint_pin_high,
    // Power conditions.
    input  wire logic                 remote_on,
    input  wire logic                 input_ok,
    input  wire logic                 input_low,
    input  wire logic                 output_in_reg,
    input  wire logic                 hold_expiring,
    // Results.
    output logic [3:0]                slot_addr,
    output logic [6:0]                bus_addr,
    output logic [7:0]                setpoint,
    output logic                      setpoint_fw_owned,
    output logic                      main_enable,
    output logic                      power_good_n,
    output logic                      input_ok_indicator,
    output logic                      invalid_cmd
);

    ////////////////////////////////////////////////////////////////////////////
    // Counts and state.

    localparam logic [31:0] START_CYC = `PSAC_START_DELAY_CYC;
    localparam logic [31:0] RISE_CYC  = `PSAC_RISE_MAX_CYC;
    localparam logic [31:0] BLINK_CYC = `PSAC_BLINK_HALF_CYC;

    typedef struct packed {
        logic                  latched;
        logic [3:0]            slot;
        logic                  fw_owned;
        logic [7:0]            fw_setpoint;
        logic                  fw_off;
        psac_pkg::psac_seq_t   seq;
        logic [31:0]           timer;
        logic                  pg_n;
        logic [31:0]           blink_cnt;
        logic                  led;
        psac_pkg::psac_match_t match;
        logic                  invalid;
        logic [7:0]            setpoint;
    } psac_state_t;

    psac_state_t state_reg;
    psac_state_t state_next;

    logic [3:0] unit_num;
    logic [3:0] rack_num;
    logic [3:0] table_slot;

    ////////////////////////////////////////////////////////////////////////////
    // Level quantisers and the slot table.

    psac_level_decode u_unit_dec (
        .is_rack (1'b0),
        .level   (unit_select_input),
        .pos     (unit_num)
    );

    psac_level_decode u_rack_dec (
        .is_rack (1'b1),
        .level   (rack_select_input),
        .pos     (rack_num)
    );

    psac_slot_decode u_slot (
        .unit_num  (unit_num),
        .rack_num  (rack_num),
        .slot_addr (table_slot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    always_comb begin
        logic [6:0] own_addr;
        logic       dir_read;
        logic       off_req;
        own_addr   = 7'h00;
        dir_read   = 1'b0;
        off_req    = 1'b0;
        state_next = state_reg;

        // The strap levels are caught once, on the first edge after release.
        if (!state_reg.latched) begin
            state_next.latched = 1'b1;
            state_next.slot    = mode_rs485 ? `PSAC_FACTORY_SLOT : table_slot;
        end

        // Address match with direction bit, broadcast reads flagged invalid.
        own_addr = {`PSAC_ADDR_PREFIX, state_reg.slot};
        dir_read = addr_byte[0];
        state_next.match = '0;
        if (addr_valid && state_reg.latched) begin
            if (addr_byte[7:1] == own_addr) begin
                state_next.match.hit = 1'b1;
            end else if (addr_byte[7:1] == `PSAC_BCAST_ADDR) begin
                if (dir_read) begin
                    state_next.match.invalid = 1'b1;
                    state_next.invalid       = 1'b1;
                end else begin
                    state_next.match.hit   = 1'b1;
                    state_next.match.bcast = 1'b1;
                end
            end
        end

        // Setpoint takeover stays until the bias reset.
        if (fw_cmd.valid && fw_cmd.code == `PSAC_CMD_SETPOINT) begin
            state_next.fw_owned    = 1'b1;
            state_next.fw_setpoint = fw_cmd.data;
        end
        if (state_reg.fw_owned) begin
            state_next.setpoint = state_reg.fw_setpoint;
        end else if (setpoint_pin_open || setpoint_pin_high) begin
            state_next.setpoint = `PSAC_SETPOINT_DEFAULT;
        end else begin
            state_next.setpoint = setpoint_pin;
        end

        // Firmware off holds until a firmware on command.
        if (fw_off_cmd) begin
            state_next.fw_off = 1'b1;
        end else if (fw_on_cmd) begin
            state_next.fw_off = 1'b0;
        end
        off_req = !remote_on || state_reg.fw_off || fw_off_cmd;

        // Output sequencing with power-good.
        unique case (state_reg.seq)
            psac_pkg::PSAC_OFF: begin
                state_next.pg_n  = 1'b1;
                state_next.timer = 32'h0;
                if (input_ok && !off_req) begin
                    state_next.seq = psac_pkg::PSAC_DELAY;
                end
            end
            psac_pkg::PSAC_DELAY: begin
                state_next.timer = state_reg.timer + 32'h1;
                if (!input_ok || off_req) begin
                    state_next.seq = psac_pkg::PSAC_OFF;
                end else if (state_reg.timer >= START_CYC - 32'h1) begin
                    state_next.seq   = psac_pkg::PSAC_RISE;
                    state_next.timer = 32'h0;
                end
            end
            psac_pkg::PSAC_RISE: begin
                state_next.timer = state_reg.timer + 32'h1;
                if (!input_ok || off_req) begin
                    state_next.seq = psac_pkg::PSAC_OFF;
                end else if (output_in_reg) begin
                    state_next.seq  = psac_pkg::PSAC_ON;
                    state_next.pg_n = 1'b0;
                end else if (state_reg.timer >= RISE_CYC - 32'h1) begin
                    state_next.seq = psac_pkg::PSAC_OFF;
                end
            end
            psac_pkg::PSAC_ON: begin
                if (off_req || hold_expiring || !input_ok) begin
                    state_next.pg_n = 1'b1;
                    state_next.seq  = off_req ? psac_pkg::PSAC_OFF : psac_pkg::PSAC_WARN;
                end
            end
            psac_pkg::PSAC_WARN: begin
                state_next.pg_n = 1'b1;
                // An off request must win over recovery, or the output would stay on.
                if (off_req) begin
                    state_next.seq = psac_pkg::PSAC_OFF;
                end else if (input_ok && !hold_expiring) begin
                    state_next.seq   = psac_pkg::PSAC_RISE;
                    state_next.timer = 32'h0;
                end else if (!output_in_reg) begin
                    state_next.seq = psac_pkg::PSAC_OFF;
                end
            end
        endcase

        // Indicator blinks on low input, otherwise steady at the input_ok level.
        if (input_low) begin
            if (state_reg.blink_cnt >= BLINK_CYC - 32'h1) begin
                state_next.blink_cnt = 32'h0;
                state_next.led       = !state_reg.led;
            end else begin
                state_next.blink_cnt = state_reg.blink_cnt + 32'h1;
            end
        end else begin
            state_next.blink_cnt = 32'h0;
            state_next.led       = input_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register; reset models the bias-power cycle.

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg          <= '0;
            state_reg.seq      <= psac_pkg::PSAC_OFF;
            state_reg.pg_n     <= 1'b1;
            state_reg.setpoint <= `PSAC_SETPOINT_DEFAULT;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Output enable follows the sequencer, cut on the next clock edge by any off request.
    assign main_enable        = (state_reg.seq == psac_pkg::PSAC_RISE ||
                                 state_reg.seq == psac_pkg::PSAC_ON ||
                                 state_reg.seq == psac_pkg::PSAC_WARN);
    assign slot_addr          = state_reg.slot;
    assign bus_addr           = {`PSAC_ADDR_PREFIX, state_reg.slot};
    assign addr_match         = state_reg.match;
    assign setpoint           = state_reg.setpoint;
    assign setpoint_fw_owned  = state_reg.fw_owned;
    assign power_good_n       = state_reg.pg_n;
    assign input_ok_indicator = state_reg.led;
    assign invalid_cmd        = state_reg.invalid;

endmodule // psac_owner

//--- verif/psac_owner_asserts.sv
`timescale 1ns/1ps
`include "psac_defines.svh"
// Watches the owner block ports for address, setpoint and sequencing behaviour.
module psac_owner_asserts (
    // Clock and reset.
    input wire logic                  mclk,
    input wire logic                  rst_n,
    // Address phase and commands.
    input wire logic                  addr_valid,
    input wire logic [7:0]            addr_byte,
    input wire psac_pkg::psac_match_t addr_match,
    input wire psac_pkg::psac_cmd_t   fw_cmd,
    input wire logic                  fw_off_cmd,
    // Pins and power conditions.
    input wire logic                  setpoint_pin_open,
    input wire logic                  setpoint_pin_high,
    input wire logic                  remote_on,
    input wire logic                  input_ok,
    input wire logic                  output_in_reg,
    // Results.
    input wire logic [3:0]            slot_addr,
    input wire logic [7:0]            setpoint,
    input wire logic                  setpoint_fw_owned,
    input wire logic                  main_enable,
    input wire logic                  power_good_n,
    input wire logic                  invalid_cmd
);
    logic [19:0] run_cnt;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    // Counts cycles with input and remote enable both present, saturating.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            run_cnt <= 20'h0;
        end else if (!(input_ok && remote_on)) begin
            run_cnt <= 20'h0;
        end else if (run_cnt != 20'hfffff) begin
            run_cnt <= run_cnt + 20'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address phase checks.
    property p_hit;
        addr_valid && addr_byte[7:1] == {3'h6, slot_addr} |=> addr_match.hit;
    endproperty
    a_hit: assert property (p_hit) else $error("own address not matched");
    property p_miss;
        addr_valid && addr_byte[7:5] != 3'h6 && addr_byte[7:1] != 7'h00 |=> addr_match == '0;
    endproperty
    a_miss: assert property (p_miss) else $error("foreign address matched");
    property p_bc_wr;
        addr_valid && addr_byte == 8'h00 |=> addr_match.bcast && !addr_match.invalid;
    endproperty
    a_bc_wr: assert property (p_bc_wr) else $error("broadcast write missed");
    property p_bc_rd;
        addr_valid && addr_byte == 8'h01 |=> addr_match.invalid && !addr_match.hit ##1 invalid_cmd;
    endproperty
    a_bc_rd: assert property (p_bc_rd) else $error("broadcast read served");

    ////////////////////////////////////////////////////////////////////////////
    // Setpoint ownership checks.
    property p_take;
        fw_cmd.valid && fw_cmd.code == 8'h21 |=> setpoint_fw_owned ##1
            setpoint == $past(fw_cmd.data, 2);
    endproperty
    a_take: assert property (p_take) else $error("setpoint command not taken");
    property p_dflt;
        !setpoint_fw_owned && (setpoint_pin_open || setpoint_pin_high) ##1 !setpoint_fw_owned
            |-> setpoint == `PSAC_SETPOINT_DEFAULT;
    endproperty
    a_dflt: assert property (p_dflt) else $error("default setpoint not used");

    ////////////////////////////////////////////////////////////////////////////
    // Output sequencing checks.
    property p_off;
        !remote_on || fw_off_cmd |=> !main_enable;
    endproperty
    a_off: assert property (p_off) else $error("output on while off requested");
    property p_delay;
        $rose(main_enable) |-> run_cnt >= 20'h186a0;
    endproperty
    a_delay: assert property (p_delay) else $error("output started too early");
    property p_pg_up;
        $fell(power_good_n) |-> $past(output_in_reg) && main_enable;
    endproperty
    a_pg_up: assert property (p_pg_up) else $error("power good before regulation");

    c_bc_rd: cover property (addr_valid && addr_byte == 8'h01);
    c_take: cover property (fw_cmd.valid && fw_cmd.code == 8'h21);
    c_pg: cover property ($fell(power_good_n));
endmodule // psac_owner_asserts

bind psac_owner psac_owner_asserts u_chk (
    .mclk, .rst_n, .addr_valid, .addr_byte, .addr_match, .fw_cmd, .fw_off_cmd,
    .setpoint_pin_open, .setpoint_pin_high, .remote_on, .input_ok, .output_in_reg,
    .slot_addr, .setpoint, .setpoint_fw_owned, .main_enable, .power_good_n, .invalid_cmd
);

//--- verif/psac_host_model.sv
`timescale 1ns/1ps
// Host controller model that issues address phases as the bus master.
module psac_host_model (
    // Clock.
    input  wire logic                  mclk,
    // Address phase towards the block.
    output logic                       addr_valid,
    output logic [7:0]                 addr_byte,
    input  wire psac_pkg::psac_match_t addr_match
);
    logic bad_ok = 1'b0;

    // Idle bus at time zero.
    initial begin
        addr_valid = 1'b0;
        addr_byte = 8'h5a;
    end

    // One address phase; a released byte shows its inverse, not the old value.
    task automatic xfer(input logic [7:0] b, output psac_pkg::psac_match_t m);
        m = '0;
        if (b == 8'h01 && !bad_ok) return;
        @(negedge mclk);
        addr_valid = 1'b1;
        addr_byte = b;
        @(negedge mclk);
        addr_valid = 1'b0;
        addr_byte = ~b;
        m = addr_match;
    endtask

    // Broadcast write, then a read of one supply to confirm it acted.
    task automatic bcast(input logic [6:0] own, output psac_pkg::psac_match_t mb,
                         output psac_pkg::psac_match_t mr);
        xfer(8'h00, mb);
        xfer({own, 1'b1}, mr);
    endtask
endmodule // psac_host_model

//--- verif/psu_address_and_control_owner_test.sv
`timescale 1ns/1ps
`include "psac_defines.svh"
// Self-checking bench for the address and control owner block.
module psu_address_and_control_owner_test;
    logic                  mclk = 1'b0;
    logic                  rst_n = 1'b0;
    logic [7:0]            unit_select_input, rack_select_input, setpoint_pin, addr_byte, d;
    logic                  mode_rs485, addr_valid, fw_off_cmd, fw_on_cmd;
    logic                  setpoint_pin_open, setpoint_pin_high, remote_on, input_ok;
    logic                  input_low, output_in_reg, hold_expiring, invalid_cmd;
    logic                  setpoint_fw_owned, main_enable, power_good_n, input_ok_indicator;
    logic [3:0]            slot_addr;
    logic [6:0]            bus_addr;
    logic [7:0]            setpoint;
    psac_pkg::psac_match_t addr_match, m, m2;
    psac_pkg::psac_cmd_t   fw_cmd;
    int                    err_total = 0;
    int                    n_tests = 0;
    int                    seed = 32'hb20e18cb;
    int                    n;
    int                    ucode[11] = '{255, 232, 206, 181, 155, 130, 104, 79, 53, 28, 0};
    int                    rcode[9] = '{0, 255, 216, 178, 139, 108, 77, 39, 0};

    // Clock at 50 MHz.
    always #10 mclk = ~mclk;

    psac_owner DUT (.mclk, .rst_n, .unit_select_input, .rack_select_input, .mode_rs485,
        .addr_valid, .addr_byte, .addr_match, .fw_cmd, .fw_off_cmd, .fw_on_cmd,
        .setpoint_pin, .setpoint_pin_open, .setpoint_pin_high, .remote_on, .input_ok,
        .input_low, .output_in_reg, .hold_expiring, .slot_addr, .bus_addr, .setpoint,
        .setpoint_fw_owned, .main_enable, .power_good_n, .input_ok_indicator, .invalid_cmd);
    psac_host_model u_host (.mclk, .addr_valid, .addr_byte, .addr_match);

    // Compare one result with its expected value.
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Print the counts and the verdict, then stop.
    task automatic final_report();
        $display("checks=%0d errors=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Wait a number of falling edges.
    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    // Bias power cycle, then idle until requests are allowed.
    task automatic bias_cycle();
        @(negedge mclk);
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(2);
    endtask

    // Reference slot address for a unit and rack position.
    function automatic int exp_slot(input int u, input int r);
        if (u <= 4 && r <= 4) return 4 * (r - 1) + u - 1;
        if (u <= 5 && r <= 5) return 0;
        if (u <= 5) return 5 * (r - 6) + u - 1;
        if (u <= 7) return 2 * (r - 1) + u - 6;
        return (r >= 4) ? 3 * (r - 4) + u - 8 : 0;
    endfunction

    // Main sequence.
    initial begin
        {unit_select_input, rack_select_input, setpoint_pin} = '0;
        {mode_rs485, fw_off_cmd, fw_on_cmd, setpoint_pin_open, setpoint_pin_high} = '0;
        {remote_on, input_ok, input_low, output_in_reg, hold_expiring} = '0;
        fw_cmd = '0;
        cyc(6);
        rst_n = 1'b1;
        cyc(2);
        // Every strap combination, own read, foreign address, strap change.
        for (int u = 1; u <= 10; u++) begin
            for (int r = 1; r <= 8; r++) begin
                unit_select_input = 8'(ucode[u]);
                rack_select_input = 8'(rcode[r]);
                bias_cycle();
                d = 8'(exp_slot(u, r));
                chk({4'h0, slot_addr}, d);
                chk({1'b0, bus_addr}, {1'b0, 3'h6, d[3:0]});
                unit_select_input = 8'($random(seed));
                u_host.xfer({3'h6, d[3:0], 1'b1}, m);
                chk({5'h0, m}, 8'h4);
                chk({4'h0, slot_addr}, d);
                u_host.xfer({3'h7, 5'($random(seed))}, m);
                chk({5'h0, m}, 8'h0);
            end
        end
        // Broadcast write with confirmation, then a commanded broadcast read.
        u_host.bcast({3'h6, d[3:0]}, m, m2);
        chk({5'h0, m}, 8'h6);
        chk({5'h0, m2}, 8'h4);
        u_host.bad_ok = 1'b1;
        u_host.xfer(8'h01, m);
        chk({5'h0, m}, 8'h1);
        u_host.bad_ok = 1'b0;
        u_host.xfer({3'h6, d[3:0], 1'b0}, m);
        chk({4'h0, m[2], invalid_cmd, 2'h0}, 8'hc);
        // Factory mode uses its fixed slot and ignores the straps.
        unit_select_input = 8'(ucode[10]);
        mode_rs485 = 1'b1;
        bias_cycle();
        chk({4'h0, slot_addr}, {4'h0, `PSAC_FACTORY_SLOT});
        mode_rs485 = 1'b0;
        bias_cycle();
        chk({4'h0, slot_addr}, d);
        // Pin owns the setpoint; open or high pin gives the default.
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed)) & 8'h7f;
            setpoint_pin = d;
            setpoint_pin_high = i[0];
            setpoint_pin_open = i[1];
            cyc(2);
            chk(setpoint, (i == 0) ? d : `PSAC_SETPOINT_DEFAULT);
        end
        {setpoint_pin_open, setpoint_pin_high} = 2'h0;
        fw_cmd = '{1'b1, 8'h20, 8'h11};
        @(negedge mclk);
        fw_cmd = '{1'b1, 8'h21, d ^ 8'h5a};
        chk({7'h0, setpoint_fw_owned}, 8'h0);
        @(negedge mclk);
        fw_cmd = '0;
        setpoint_pin = ~d;
        cyc(2);
        chk({7'h0, setpoint_fw_owned}, 8'h1);
        chk(setpoint, d ^ 8'h5a);
        bias_cycle();
        chk({7'h0, setpoint_fw_owned}, 8'h0);
        chk(setpoint, ~d);
        // Start-up delay, power good, warning, firmware off.
        input_ok = 1'b1;
        remote_on = 1'b1;
        for (n = 0; n < 110000 && main_enable !== 1'b1; n++) cyc(1);
        if (n == 110000) begin
            err_total++;
        end
        chk(8'(n >= 100000), 8'h1);
        chk({7'h0, power_good_n}, 8'h1);
        chk({7'h0, input_ok_indicator}, 8'h1);
        output_in_reg = 1'b1;
        cyc(2);
        chk({7'h0, power_good_n}, 8'h0);
        hold_expiring = 1'b1;
        cyc(1);
        chk({6'h0, main_enable, power_good_n}, 8'h3);
        hold_expiring = 1'b0;
        cyc(3);
        chk({6'h0, main_enable, power_good_n}, 8'h2);
        fw_off_cmd = 1'b1;
        cyc(1);
        fw_off_cmd = 1'b0;
        chk({6'h0, main_enable, power_good_n}, 8'h1);
        input_low = 1'b1;
        fw_on_cmd = 1'b1;
        cyc(1);
        {input_low, fw_on_cmd, input_ok} = 3'h0;
        cyc(2);
        chk({7'h0, input_ok_indicator}, 8'h0);
        final_report();
    end
endmodule // psu_address_and_control_owner_test
